/* src/sbs_cfg.svh */
// Named constants for the host-side SDRAM burst sequencer.
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
// Clocking: memory clock is the system clock divided by four.
`define MCLK_NS      8
`define CK_DIV       4
`define TCK_NS       (`MCLK_NS * `CK_DIV)
`define PH_CMD       2'h2
// Burst shape and read latency in memory clocks.
`define BL           4
`define CL           3
`define NBANK        4
`define A10_BIT      10
// Device timings in their own units.
`define TRP_NS       18
`define ROW_ACTIVE_MIN_TIME_NS      42
`define TRC_NS       60
`define TWR_NS       15
`define WRITE_TO_READ_DELAY_CK      2
`define WRITE_STROBE_DELAY_MCLK   4
// Least times rounded up to whole memory clocks.
`define TRP_CK       ((`TRP_NS + `TCK_NS - 1) / `TCK_NS)
`define ROW_ACTIVE_MIN_TIME_CK      ((`ROW_ACTIVE_MIN_TIME_NS + `TCK_NS - 1) / `TCK_NS)
`define TRC_CK       ((`TRC_NS + `TCK_NS - 1) / `TCK_NS)
`define TWR_CK       ((`TWR_NS + `TCK_NS - 1) / `TCK_NS)
`define WB_END_CK    (1 + `BL / 2)
// System-clock offsets from launch of a command.
`define CMD_LAT      3
`define SYNC_LAT     2
`define WS_RISE0     (`CMD_LAT + `WRITE_STROBE_DELAY_MCLK)
`define RD_CAP0      (`CMD_LAT + `CK_DIV * `CL + 1 + `SYNC_LAT)
// Masking starts in the first slot of an element, so the mask moves one slot before that element's strobe edge.
`define MASK_FROM    (`CMD_LAT - 2)
// Storage sizes and widths.
`define WS_DEPTH     16
`define RS_DEPTH     32
`define CNT_W        8
`define DM_NONE      2'h3
// Command pin codes, {ras_n, cas_n, we_n}.
`define CODE_NOP     3'h7
`define CODE_ACT     3'h3
`define CODE_RD      3'h5
`define CODE_WR      3'h4
`define CODE_PRE     3'h2
`define CODE_BT      3'h6
`endif

/* src/sbs_pkg.sv */
// Types shared by the SDRAM burst sequencer.
`include "sbs_cfg.svh"
package sbs_pkg;
    // Commands a user may request.
    typedef enum logic [2:0] {SBS_NOP, SBS_ACT, SBS_RD, SBS_WR, SBS_PRE, SBS_BT} sbs_cmd_e;
    // One user request with its whole write burst.
    typedef struct packed {
        sbs_cmd_e         cmd;
        logic [1:0]       bank;
        logic [12:0]      addr;
        logic             ap;
        logic             trunc;
        logic [3:0][15:0] wdata;
        logic [3:0][1:0]  wmask;
    } sbs_req_s;
    // Command and address pins toward the memory.
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        bank_select_bit1;
        logic        bank_select_bit0;
        logic [12:0] addr;
    } sbs_pins_s;
    // One system-clock slot of the write-data schedule.
    typedef struct packed {
        logic        dqs_oe;
        logic        dq_oe;
        logic        dqs;
        logic [15:0] wdq;
        logic [1:0]  dm;
    } sbs_ws_s;
    localparam sbs_ws_s SBS_WS_IDLE = '{dqs_oe: 1'b0, dq_oe: 1'b0, dqs: 1'b0, wdq: 16'h0000, dm: `DM_NONE};
    localparam sbs_pins_s SBS_PINS_IDLE = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                            bank_select_bit1: 1'b0, bank_select_bit0: 1'b0, addr: 13'h0000};
endpackage

/* src/sbs_ctrl.sv */
// Host-side controller that sequences read, write and precharge bursts on a mobile DDR SDRAM.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"
// How it works
// - Chained read issued pairs-kept ticks later.
// - Terminate cuts reads at read latency.
// - Write waits for read data to finish.
// - Precharge after read truncates by spacing.
// - Bank stays untouched until precharge time passes.
// - Full read burst needs half-burst precharge spacing.
// - Precharge only after row active minimum time.
// - Terminate never used to end writes.
// - Strobe preamble, element per edge, postamble.
// - First strobe rise one clock after write.
// - Chained write restarts data flow seamlessly.
// - Read waits write-to-read delay after write.
// - Read cutting a write masks later elements.
// - Precharge waits write recovery after write.
// - Precharge cutting a write masks later elements.
module sbs_ctrl
    import sbs_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // User request port.
    input  wire logic        req_valid,
    input  wire sbs_req_s    req,
    output logic             req_ready,
    // Read data stream, one element per pulse.
    output logic             rd_valid,
    output logic [15:0]      rd_data,
    // Memory clock and command pins.
    output logic             mem_ck,
    output sbs_pins_s        mem_pins,
    // Data and strobe pins, split into input, output and enable.
    input  wire logic [15:0] dq_in,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    input  wire logic        dqs_in,
    output logic             dqs_out,
    output logic             dqs_oe,
    output logic [1:0]       write_byte_mask
);
    logic [1:0]            ph_ff;        // Phase within one memory clock.
    logic                  ck_ff;        // Divided memory clock.
    logic                  tick;         // Command launch slot.
    logic                  ok;           // Request is legal now.
    logic                  launch;       // Request accepted this cycle.
    logic [`NBANK-1:0]     open_v;       // Banks with an open row.
    logic [`NBANK-1:0]     rp_z;         // Precharge time elapsed.
    logic [`NBANK-1:0]     rc_z;         // Row cycle time elapsed.
    logic [`NBANK-1:0]     pre_v;        // Bank may be precharged now.
    logic [`CNT_W-1:0]     wtr_ff;       // Ticks until a read may follow a write.
    sbs_ws_s               ws_ff [`WS_DEPTH]; // Write schedule, slot 0 drives the pins.
    logic [`WS_DEPTH-1:0]  ws_oe_v;      // Slots still carrying write data.
    logic                  ws_busy;      // Write data still pending.
    logic [`RS_DEPTH-1:0]  rs_ff;        // Read capture schedule, bit 0 is due now.
    logic [`RS_DEPTH-1:0]  nxt_rs;
    logic                  rd_go;        // Read launched.
    logic                  wr_go;        // Write launched.
    logic                  cut_go;       // Pending read elements are dropped.
    logic                  mask_go;      // Pending write elements are masked.
    logic [1:0]            last_rd_bank_ff; // Bank of the latest read.
    logic                  last_rd_ap_ff;   // Latest read had auto precharge.
    logic [15:0]           dq_s1_ff;     // First synchroniser stage.
    logic [15:0]           dq_s2_ff;     // Second synchroniser stage.
    logic                  rd_valid_ff;
    logic [15:0]           rd_data_ff;
    sbs_pins_s             pins_ff;
    sbs_pins_s             nxt_pins;

    // Capture slots kept when reads are cut; cut slots start at read latency.
    localparam logic [`RS_DEPTH-1:0] KEEP_MASK = (`RS_DEPTH)'((64'h1 << (`RD_CAP0 - 1)) - 64'h1);

    // Builds the capture pattern of one read burst, one slot per element.
    function automatic logic [`RS_DEPTH-1:0] rd_pattern();
        rd_pattern = '0;
        for (int e = 0; e < `BL; e++) begin
            rd_pattern[`RD_CAP0 - 1 + 2 * e] = 1'b1;
        end
    endfunction

    // Builds write slot j counted from launch: strobe, data, mask.
    function automatic sbs_ws_s ws_val(input int j, input sbs_req_s r);
        int e;
        ws_val = SBS_WS_IDLE;
        e = (j - `WS_RISE0 + 1) >> 1;
        ws_val.dqs_oe = (j >= `WS_RISE0 - 2) && (j <= `WS_RISE0 + 2 * `BL - 1);
        ws_val.dq_oe  = (j >= `WS_RISE0 - 1) && (j <= `WS_RISE0 + 2 * `BL - 2);
        ws_val.dqs    = ws_val.dqs_oe && (j >= `WS_RISE0) && (((j - `WS_RISE0) >> 1) % 2 == 0);
        if (ws_val.dq_oe) begin
            ws_val.wdq = r.wdata[e[1:0]];
            ws_val.dm  = r.wmask[e[1:0]];
        end
    endfunction

    // Maps a command onto the row, column and write-enable pins.
    function automatic logic [2:0] cmd_code(input sbs_cmd_e c);
        unique case (c)
            SBS_ACT: cmd_code = `CODE_ACT;
            SBS_RD:  cmd_code = `CODE_RD;
            SBS_WR:  cmd_code = `CODE_WR;
            SBS_PRE: cmd_code = `CODE_PRE;
            SBS_BT:  cmd_code = `CODE_BT;
            default: cmd_code = `CODE_NOP;
        endcase
    endfunction

    // Divides the system clock by four; the memory clock rises as phase one begins.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph_ff <= 2'h0;
            ck_ff <= 1'b0;
        end else begin
            ph_ff <= ph_ff + 2'h1;
            ck_ff <= ~ph_ff[1];
        end
    end
    assign mem_ck = ck_ff;
    // Commands change at the falling edge so they are stable at the next rise.
    assign tick = (ph_ff == `PH_CMD);

    // Per-bank open flag and timers, counted in memory clocks.
    for (genvar i = 0; i < `NBANK; i++) begin : g_bank
        logic              open_ff;
        logic [`CNT_W-1:0] rp_ff;
        logic [`CNT_W-1:0] ras_ff;
        logic [`CNT_W-1:0] rc_ff;
        logic [`CNT_W-1:0] wr_ff;
        logic              hit;     // Launch addresses this bank.
        logic              pre_hit; // Precharge selects this bank.
        assign hit     = launch && (req.bank == 2'(i));
        assign pre_hit = launch && (req.cmd == SBS_PRE) && (req.ap || req.bank == 2'(i));
        // An auto precharge closes the row for this one command only.
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                open_ff <= 1'b0;
            end else if (hit && req.cmd == SBS_ACT) begin
                open_ff <= 1'b1;
            end else if (pre_hit || (hit && (req.cmd == SBS_RD || req.cmd == SBS_WR) && req.ap)) begin
                open_ff <= 1'b0;
            end
        end
        // Precharge timer; a precharge to a closed bank leaves it alone.
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                rp_ff <= '0;
            end else if (pre_hit && open_ff) begin
                rp_ff <= (`CNT_W)'(`TRP_CK);
            end else if (hit && req.cmd == SBS_RD && req.ap) begin
                rp_ff <= (`CNT_W)'(`BL / 2 + `TRP_CK);
            end else if (hit && req.cmd == SBS_WR && req.ap) begin
                rp_ff <= (`CNT_W)'(`WB_END_CK + `TWR_CK + `TRP_CK);
            end else if (tick && rp_ff != '0) begin
                rp_ff <= rp_ff - (`CNT_W)'(1);
            end
        end
        // Row active and row cycle timers start at activation.
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                ras_ff <= '0;
                rc_ff  <= '0;
            end else if (hit && req.cmd == SBS_ACT) begin
                ras_ff <= (`CNT_W)'(`ROW_ACTIVE_MIN_TIME_CK);
                rc_ff  <= (`CNT_W)'(`TRC_CK);
            end else if (tick) begin
                ras_ff <= (ras_ff != '0) ? ras_ff - (`CNT_W)'(1) : ras_ff;
                rc_ff  <= (rc_ff != '0) ? rc_ff - (`CNT_W)'(1) : rc_ff;
            end
        end
        // Write recovery timer runs from launch through the burst.
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                wr_ff <= '0;
            end else if (hit && req.cmd == SBS_WR) begin
                wr_ff <= (`CNT_W)'(`WB_END_CK + `TWR_CK);
            end else if (tick && wr_ff != '0) begin
                wr_ff <= wr_ff - (`CNT_W)'(1);
            end
        end
        assign open_v[i] = open_ff;
        assign rp_z[i]   = (rp_ff == '0);
        assign rc_z[i]   = (rc_ff == '0);
        // A truncating precharge may skip write recovery; its data gets masked.
        assign pre_v[i]  = !open_ff || ((ras_ff == '0) && (wr_ff == '0 || req.trunc));
    end

    // Decides whether the request may go out at this slot.
    always_comb begin
        unique case (req.cmd)
            SBS_NOP: ok = 1'b1;
            SBS_ACT: ok = !open_v[req.bank] && rp_z[req.bank] && rc_z[req.bank];
            SBS_RD:  ok = open_v[req.bank] && rp_z[req.bank] && (wtr_ff == '0 || req.trunc);
            SBS_WR:  ok = open_v[req.bank] && rp_z[req.bank] && (rs_ff == '0);
            SBS_PRE: ok = req.ap ? (&pre_v) : pre_v[req.bank];
            SBS_BT:  ok = !ws_busy;
            default: ok = 1'b0;
        endcase
    end
    assign req_ready = tick && ok;
    assign launch    = req_valid && req_ready;
    assign rd_go     = launch && (req.cmd == SBS_RD);
    assign wr_go     = launch && (req.cmd == SBS_WR);
    // Terminate hits the latest read unless it closes itself; precharge hits its bank.
    assign cut_go    = launch && ((req.cmd == SBS_BT && !last_rd_ap_ff) ||
                       (req.cmd == SBS_PRE && (req.ap || req.bank == last_rd_bank_ff)));
    assign mask_go   = launch && (req.cmd == SBS_RD || req.cmd == SBS_PRE) && ws_busy;

    // Read-after-write delay counted from launch past the end of the burst.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wtr_ff <= '0;
        end else if (wr_go) begin
            wtr_ff <= (`CNT_W)'(`WB_END_CK + `TWR_CK * 0 + `WRITE_TO_READ_DELAY_CK);
        end else if (tick && wtr_ff != '0) begin
            wtr_ff <= wtr_ff - (`CNT_W)'(1);
        end
    end

    // Remembers the latest read so terminate and precharge know what to cut.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_rd_bank_ff <= 2'h0;
            last_rd_ap_ff   <= 1'b0;
        end else if (rd_go) begin
            last_rd_bank_ff <= req.bank;
            last_rd_ap_ff   <= req.ap;
        end
    end

    // Write schedule: a new write overwrites everything from its preamble on,
    // which gives concatenation and truncation with the same logic.
    for (genvar k = 0; k < `WS_DEPTH; k++) begin : g_ws
        sbs_ws_s nxt_e;
        sbs_ws_s shift_in;
        if (k == `WS_DEPTH - 1) begin : g_top
            assign shift_in = SBS_WS_IDLE;
        end else begin : g_mid
            assign shift_in = ws_ff[k + 1];
        end
        always_comb begin
            nxt_e = shift_in;
            if (wr_go && (k + 1 >= `WS_RISE0 - 2)) begin
                nxt_e = ws_val(k + 1, req);
            end
            if (mask_go && (k >= `MASK_FROM)) begin
                nxt_e.dm = `DM_NONE;
            end
        end
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                ws_ff[k] <= SBS_WS_IDLE;
            end else begin
                ws_ff[k] <= nxt_e;
            end
        end
        assign ws_oe_v[k] = ws_ff[k].dq_oe;
    end
    assign ws_busy         = |ws_oe_v;
    assign dq_out          = ws_ff[0].wdq;
    assign dq_oe           = ws_ff[0].dq_oe;
    assign dqs_out         = ws_ff[0].dqs;
    assign dqs_oe          = ws_ff[0].dqs_oe;
    assign write_byte_mask = ws_ff[0].dm;

    // Read capture schedule: chained reads simply add their slots.
    always_comb begin
        nxt_rs = {1'b0, rs_ff[`RS_DEPTH-1:1]};
        if (cut_go) begin
            nxt_rs = nxt_rs & KEEP_MASK;
        end
        if (rd_go) begin
            nxt_rs = nxt_rs | rd_pattern();
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rs_ff <= '0;
        end else begin
            rs_ff <= nxt_rs;
        end
    end

    // Data pins come from the memory's domain, so they pass two flops first.
    // The strobe input is not used: capture runs at a fixed latency.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
        end else begin
            dq_s1_ff <= dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // Takes one element at the last system-clock edge of its data window.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= 16'h0000;
        end else begin
            rd_valid_ff <= rs_ff[0];
            rd_data_ff  <= rs_ff[0] ? dq_s2_ff : rd_data_ff;
        end
    end
    assign rd_valid = rd_valid_ff;
    assign rd_data  = rd_data_ff;

    // Builds the pins for this slot; idle slots carry a nop.
    always_comb begin
        nxt_pins = pins_ff;
        if (tick) begin
            nxt_pins.cke = 1'b1;
            nxt_pins.cs_n = 1'b0;
            {nxt_pins.ras_n, nxt_pins.cas_n, nxt_pins.we_n} = launch ? cmd_code(req.cmd) : `CODE_NOP;
            if (launch) begin
                {nxt_pins.bank_select_bit1, nxt_pins.bank_select_bit0} = req.bank;
                nxt_pins.addr = req.addr;
                if (req.cmd != SBS_ACT) begin
                    nxt_pins.addr[`A10_BIT] = req.ap;
                end
            end
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pins_ff <= SBS_PINS_IDLE;
        end else begin
            pins_ff <= nxt_pins;
        end
    end
    assign mem_pins = pins_ff;

    property p_dqs_first_rise;
        @(posedge mclk) disable iff (!reset_n) wr_go |-> ##7 $rose(dqs_out);
    endproperty
    a_dqs_first_rise: assert property (p_dqs_first_rise) else $error("strobe rise late");
    property p_preamble;
        @(posedge mclk) disable iff (!reset_n) wr_go |-> ##5 (dqs_oe && !dqs_out)[*2];
    endproperty
    a_preamble: assert property (p_preamble) else $error("no write preamble");
    property p_read_first;
        @(posedge mclk) disable iff (!reset_n) rd_go |-> ##19 rd_valid;
    endproperty
    a_read_first: assert property (p_read_first) else $error("read element missing");
    property p_bt_cut;
        @(posedge mclk) disable iff (!reset_n)
            (launch && req.cmd == SBS_BT && !last_rd_ap_ff) |-> ##19 !rd_valid ##2 !rd_valid;
    endproperty
    a_bt_cut: assert property (p_bt_cut) else $error("terminate did not cut");
    property p_no_contention;
        @(posedge mclk) disable iff (!reset_n) dq_oe |-> (!rd_valid && rs_ff[`CMD_LAT+`SYNC_LAT+2:0] == '0);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("write over read");
    property p_mask_trunc;
        @(posedge mclk) disable iff (!reset_n) mask_go |-> ##2 (write_byte_mask == `DM_NONE)[*8];
    endproperty
    a_mask_trunc: assert property (p_mask_trunc) else $error("cut write not masked");
    property p_pre_all;
        @(posedge mclk) disable iff (!reset_n) (launch && req.cmd == SBS_PRE && req.ap) |=> open_v == '0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("bank left open");
    property p_ap_once;
        @(posedge mclk) disable iff (!reset_n) rd_go |=> (open_v[$past(req.bank)] == !$past(req.ap));
    endproperty
    a_ap_once: assert property (p_ap_once) else $error("auto precharge wrong");
    property p_rp_wait;
        @(posedge mclk) disable iff (!reset_n)
            (launch && req.cmd == SBS_PRE && !req.ap && open_v[req.bank]) |=> !rp_z[$past(req.bank)];
    endproperty
    a_rp_wait: assert property (p_rp_wait) else $error("precharge time skipped");
endmodule
`default_nettype wire

/* verif/sbs_mem.sv */
// Behavioural memory device that answers the burst sequencer on the memory pins.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_mem
    import sbs_pkg::*;
(
    // Memory clock and command pins.
    input  wire logic        mem_ck,
    input  wire sbs_pins_s   mem_pins,
    // Write data, strobe and mask from the host.
    input  wire logic [15:0] dq_h,
    input  wire logic        dqs_h,
    input  wire logic        dqs_h_oe,
    input  wire logic [1:0]  dm_h,
    // Read data and strobe driven by the device.
    output logic [15:0]      dq_m,
    output logic             dqs_m
);
    logic [15:0] mem [256];   // Storage, indexed by bank and low column bits.
    logic [16:0] slot [256];  // Read schedule per half clock; bit 16 marks a driven slot.
    logic [7:0]  hc = 8'h00;  // Half clock counter.
    logic [7:0]  wptr;        // Next location of the running write burst.
    logic [2:0]  wcnt = 3'h4; // Elements taken in the running write burst.
    logic        open [4];    // Per-bank open row flag.
    logic [1:0]  bk;          // Bank bits of the current command.
    logic [1:0]  rbank;       // Bank of the latest read.
    initial begin
        dq_m = 16'h0000;
        dqs_m = 1'b0;
        foreach (mem[i]) begin
            mem[i] = 16'h5a00 + 16'(i);
            slot[i] = 17'h0_0000;
        end
        foreach (open[i]) open[i] = 1'b0;
    end
    // Commands register on the rising edge; read data leaves on both edges a little late, as real output delay does.
    always @(mem_ck) begin
        hc = hc + 8'h01;
        dqs_m <= #1 slot[hc][16] ? mem_ck : ~dqs_m;
        dq_m <= #1 slot[hc][16] ? slot[hc][15:0] : ~dq_m;
        slot[hc] = 17'h0_0000;
        bk = {mem_pins.bank_select_bit1, mem_pins.bank_select_bit0};
        if (mem_ck && !mem_pins.cs_n) begin
            case ({mem_pins.ras_n, mem_pins.cas_n, mem_pins.we_n})
                `CODE_ACT: open[bk] = 1'b1;
                `CODE_RD: if (open[bk]) begin
                    for (int i = 0; i < 4; i++) slot[8'(hc + 8'h06 + 8'(i))] = {1'b1, mem[{bk, mem_pins.addr[5:0]} + 8'(i)]};
                    rbank = bk;
                    open[bk] = !mem_pins.addr[`A10_BIT];
                end
                `CODE_WR: if (open[bk]) begin
                    wptr = {bk, mem_pins.addr[5:0]};
                    wcnt = 3'h0;
                    open[bk] = !mem_pins.addr[`A10_BIT];
                end
                `CODE_BT, `CODE_PRE: begin
                    // A precharge cuts only the read of its own bank unless it closes all banks; terminate cuts any.
                    if (mem_pins.ras_n || mem_pins.addr[`A10_BIT] || bk == rbank) begin
                        for (int i = 0; i < 8; i++) slot[8'(hc + 8'h06 + 8'(i))] = 17'h0_0000;
                    end
                    if (!mem_pins.ras_n && mem_pins.addr[`A10_BIT]) begin
                        foreach (open[i]) open[i] = 1'b0;
                    end else if (!mem_pins.ras_n) begin
                        open[bk] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end
    // First element on the first rising strobe edge, then one per edge; extra edges are ignored.
    always @(dqs_h) begin
        if (dqs_h_oe && wcnt < 3'h4 && (wcnt != 3'h0 || dqs_h)) begin
            if (!dm_h[0]) mem[wptr][7:0] = dq_h[7:0];
            if (!dm_h[1]) mem[wptr][15:8] = dq_h[15:8];
            wptr = wptr + 8'h01;
            wcnt = wcnt + 3'h1;
        end
    end
endmodule
`default_nettype wire

/* verif/sdram_burst_sequencing_test.sv */
// Self-checking testbench of the burst sequencer against the memory model.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module sdram_burst_sequencing_test
    import sbs_pkg::*;
;
    logic             mclk = 1'b0;
    logic             reset_n = 1'b0;
    logic             req_valid = 1'b0;
    sbs_req_s         req = '0;
    logic             req_ready, rd_valid, mem_ck, dq_oe, dqs_out, dqs_oe, dqs_m, dqs_in;
    logic [15:0]      rd_data, dq_out, dq_m, dq_in;
    logic [1:0]       wbm;
    sbs_pins_s        pins;
    logic [3:0][15:0] wd = '0;  // Write burst of the next request.
    logic [3:0][1:0]  wm = '0;  // Byte masks of the next request.
    logic [1:0]       opt = 2'h0; // Truncate and auto-precharge flags of the next request.
    logic [15:0]      rq [$];   // Read elements seen since the last clear.
    int               fails = 0, n_compared = 0, cyc = 0;
    // Whoever enables its driver owns the shared data and strobe lines.
    assign dq_in  = dq_oe ? dq_out : dq_m;
    assign dqs_in = dqs_oe ? dqs_out : dqs_m;
    sbs_ctrl i_sbs_ctrl (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .mem_ck(mem_ck), .mem_pins(pins), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .write_byte_mask(wbm));
    sbs_mem i_sbs_mem (.mem_ck(mem_ck), .mem_pins(pins), .dq_h(dq_out), .dqs_h(dqs_out), .dqs_h_oe(dqs_oe),
        .dm_h(wbm), .dq_m(dq_m), .dqs_m(dqs_m));
    always #4 mclk = ~mclk;
    // Collect every read element as it is handed out.
    always @(negedge mclk) if (rd_valid === 1'b1) rq.push_back(rd_data);
    // A hang ends the run as a failure.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end
    // Holds a request until taken or until the bound runs out; the caller releases it.
    task automatic issue(input sbs_cmd_e c, input logic [1:0] b, input logic [12:0] a, input logic e);
        logic ok;
        req <= '{cmd: c, bank: b, addr: a, ap: opt[0], trunc: opt[1], wdata: wd, wmask: wm};
        req_valid <= 1'b1;
        ok = 1'b0;
        for (int n = 0; n < 300 && !ok; n++) begin
            @(negedge mclk);
            ok = (req_ready === 1'b1);
            @(posedge mclk);
        end
        `CHECK("accept", e, ok)
    endtask
    // Drops the request and lets the read data drain.
    task automatic settle();
        req_valid <= 1'b0;
        repeat (40) @(posedge mclk);
    endtask
    task automatic check_rd(input logic [15:0] e [$]);
        `CHECK("count", e.size(), rq.size())
        foreach (e[i]) `CHECK("rd_data", e[i], rq[i])
        rq.delete();
    endtask
    // Masked write, then a read that must wait out the write-to-read delay.
    task automatic t_write_read();
        wd = {16'hd3d3, 16'hd2d2, 16'hd1d1, 16'hd0d0};
        wm = {2'h3, 2'h0, 2'h1, 2'h0};
        issue(SBS_ACT, 2'h1, 13'h0000, 1'b1);
        issue(SBS_WR, 2'h1, 13'h0004, 1'b1);
        issue(SBS_RD, 2'h1, 13'h0004, 1'b1);
        settle();
        check_rd({16'hd0d0, 16'hd145, 16'hd2d2, 16'h5a47});
    endtask
    // A read one tick after another keeps one pair of the first.
    task automatic t_read_chain();
        issue(SBS_RD, 2'h1, 13'h0020, 1'b1);
        issue(SBS_RD, 2'h1, 13'h0028, 1'b1);
        settle();
        check_rd({16'h5a60, 16'h5a61, 16'h5a68, 16'h5a69, 16'h5a6a, 16'h5a6b});
    endtask
    // Terminate and precharge one tick after a read keep one pair; a closed bank refuses reads.
    task automatic t_cut();
        issue(SBS_RD, 2'h1, 13'h0030, 1'b1);
        issue(SBS_BT, 2'h0, 13'h0000, 1'b1);
        settle();
        check_rd({16'h5a70, 16'h5a71});
        issue(SBS_RD, 2'h1, 13'h0008, 1'b1);
        issue(SBS_PRE, 2'h1, 13'h0000, 1'b1);
        settle();
        check_rd({16'h5a48, 16'h5a49});
        issue(SBS_RD, 2'h1, 13'h0008, 1'b0);
        settle();
    endtask
    // A precharge two ticks into a write keeps one pair; auto precharge and precharge-all close banks.
    task automatic t_trunc();
        wd = {16'hc3c3, 16'hc2c2, 16'hc1c1, 16'hc0c0};
        wm = '0;
        issue(SBS_ACT, 2'h2, 13'h0000, 1'b1);
        issue(SBS_WR, 2'h2, 13'h0010, 1'b1);
        opt = 2'h2;
        issue(SBS_PRE, 2'h2, 13'h0000, 1'b1);
        opt = 2'h0;
        issue(SBS_ACT, 2'h2, 13'h0000, 1'b1);
        opt = 2'h1;
        issue(SBS_RD, 2'h2, 13'h0010, 1'b1);
        settle();
        check_rd({16'hc0c0, 16'hc1c1, 16'h5a92, 16'h5a93});
        opt = 2'h0;
        issue(SBS_ACT, 2'h3, 13'h0000, 1'b1);
        opt = 2'h1;
        issue(SBS_PRE, 2'h0, 13'h0000, 1'b1);
        opt = 2'h0;
        issue(SBS_RD, 2'h3, 13'h0000, 1'b0);
        issue(SBS_RD, 2'h2, 13'h0010, 1'b0);
        settle();
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        `CHECK("pins", SBS_PINS_IDLE, pins)
        `CHECK("mask", 2'h3, wbm)
        reset_n <= 1'b1;
        t_write_read();
        t_read_chain();
        t_cut();
        t_trunc();
        end_of_test();
    end
endmodule
`default_nettype wire
